//--- bridge_regs_map.svh
// register offsets, field positions, reset values and fixed bridge figures for the bridge register bank
// assumes a 32-bit word-addressed register port with byte offsets
`ifndef BRIDGE_REGS_MAP_SVH
`define BRIDGE_REGS_MAP_SVH
`define OFS_IRQ_FLAGS      8'h00
`define OFS_IRQ_ENABLES    8'h04
`define OFS_RUN_ENABLES    8'h08
`define OFS_CAPS           8'h0c
`define OFS_LINK_DROPS     8'h10
`define OFS_READ_INFLIGHT  8'h14
`define OFS_LINK_STATE     8'h18
`define OFS_WINDOW_SIZE    8'h1c
`define OFS_PAGE_LOW       8'h20
`define OFS_PAGE_HIGH      8'h24
`define OFS_TIMEOUT_FLAGS  8'h34
`define RST_READ_INFLIGHT  32'ha5100100
`define RST_WINDOW_SIZE    32'h003fffff
`define RST_PAGE           32'h00000000
`define WINDOW_ONES        32'h003fffff
`define IRQ_MASK_BITS      32'h0000003f
`define RUN_MASK_BITS      32'h0000001f
`define TO_SLAVE_BIT       18
`define TO_MASTER_BIT      19
`define TO_CHAN_LO         20
`define TO_DM_ERR_BIT      27
`define RATE_GEN1          3'h1
`define RATE_GEN2          3'h2
`define RATE_GEN3          3'h4
`define L0_STATE           6'h10
`define WRITE_PAYLOAD_BYTES 128
`define DATA_PATH_BITS     256
`define CLK_MHZ            250
`endif

//--- bridge_regs_pkg.sv
// types shared by the bridge register bank
// assumes nothing beyond a SystemVerilog compiler
package bridge_regs_pkg;
  typedef logic [31:0] word_t;   // one register word
  typedef logic [21:0] core_status_t; // core status port layout
endpackage

//--- bridge_regs.sv
// generic control and status register bank of the target bridge
// assumes a single-cycle register port on the 250 MHz user clock, timeout events from same clock
//
// How it works
// R1: read-only interrupt status: timeout, model, engines
// R2: read-write enables for each interrupt source
// R3: interrupt raised when any enabled status set
// R4: direct master enable bit0, engine enables 4:1
// R5: read-only capability bits: compat, overlap flag
// R6: sixteen-bit link-drop count, cleared by reset only
// R7: per-engine read limit field 27:24, reset five
// R8: control word resets a5100100, spare fields stored
// R9: report read request, payload and lane count
// R10: lane rate in 29:27, coded 1/2/4
// R11: bit 30 low when link up
// R12: window mask fixed ones/zeros, 28:22 writable
// R13: mask only narrows host-allocated window decode
// R14: page low supplies address bits 31:22
// R15: page high supplies address bits 63:32
// R16: any write to status clears timeouts
// R17: target blocked while any timeout flag set
// R18: direct master held off after timeout
// R19: timeout flags at bits 18..23 and 27
// R20: engines use 128-byte write payloads
// R21: 250 MHz clock, 256-bit data path
// R22: core status port bit layout
`timescale 1ns/1ps
`include "bridge_regs_map.svh"
module bridge_regs
  import bridge_regs_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // register port
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  output logic      [31:0]  reg_rdata,
  output logic              reg_rvalid,
  // core status port
  input  wire logic [21:0]  core_status,
  // interrupt sources
  input  wire logic         model_specific_flag,
  input  wire logic [3:0]   engine_irq,
  // capability straps
  input  wire logic [3:0]   message_interrupt_compat,
  input  wire logic         descriptor_overlap_flag,
  // timeout events, one-cycle pulses
  input  wire logic         slave_read_timeout,
  input  wire logic         master_read_timeout,
  input  wire logic [3:0]   channel_read_timeout,
  input  wire logic         master_cmd_error,
  // outputs to the bridge
  output logic              host_irq,
  output logic              fpga_to_host_path_enable,
  output logic [3:0]        engine_enable,
  output logic [3:0]        per_engine_read_limit,
  output logic              target_access_ok,
  output logic [31:0]       slave_window_mask,
  output logic [63:22]      slave_upper_addr,
  output logic [7:0]        write_payload_bytes,
  output logic [9:0]        data_path_bits
);

  // core status fields
  wire logic       link_down     = core_status[0];          // see R22
  wire logic [3:0] lane_count    = core_status[6:3];        // see R22
  wire logic [2:0] present_rate  = core_status[9:7];        // see R22
  wire logic [2:0] payload_limit = core_status[12:10];      // see R22
  wire logic [2:0] read_request_limit = core_status[15:13]; // see R22
  wire logic [5:0] train_state   = core_status[21:16];      // see R22

  // stored registers
  word_t       irq_en_q;        // interrupt enables
  word_t       run_en_q;        // path and engine enables
  word_t       inflight_q;      // read in-flight control
  logic [6:0]  window_sel_q;    // writable window bits
  word_t       page_low_q;      // page low
  word_t       page_high_q;     // page high
  logic [15:0] link_drops_q;    // link drop count
  logic        in_l0_q;         // previous L0 state
  logic [5:0]  to_flags_q;      // timeout flags 18..23
  logic        dm_err_q;        // illegal master command flag
  logic        link_up_q;       // registered link state

  // address decode
  wire logic hit_flags   = reg_addr == `OFS_IRQ_FLAGS;
  wire logic hit_caps    = reg_addr == `OFS_CAPS;
  wire logic hit_drops   = reg_addr == `OFS_LINK_DROPS;
  wire logic hit_link    = reg_addr == `OFS_LINK_STATE;
  wire logic hit_irq_en  = reg_addr == `OFS_IRQ_ENABLES;
  wire logic hit_run_en  = reg_addr == `OFS_RUN_ENABLES;
  wire logic hit_inflt   = reg_addr == `OFS_READ_INFLIGHT;
  wire logic hit_window  = reg_addr == `OFS_WINDOW_SIZE;
  wire logic hit_pgl     = reg_addr == `OFS_PAGE_LOW;
  wire logic hit_pgh     = reg_addr == `OFS_PAGE_HIGH;
  wire logic hit_to      = reg_addr == `OFS_TIMEOUT_FLAGS;

  // event and level terms
  wire logic in_l0       = train_state == `L0_STATE;
  wire logic left_l0     = in_l0_q & ~in_l0;
  wire logic any_timeout = (|to_flags_q) | dm_err_q;
  wire logic clear_to    = reg_wr & hit_to;                 // see R16
  wire logic [5:0] to_events = {channel_read_timeout, master_read_timeout, slave_read_timeout};

  // interrupt status word
  wire word_t irq_flags = {26'h0, engine_irq, model_specific_flag, any_timeout}; // see R1

  // capability word: straps only, nothing stored
  wire word_t caps_word = {27'h0, descriptor_overlap_flag, message_interrupt_compat}; // see R5

  // window mask word: fixed ones below, fixed zeros above
  wire word_t window_word = {3'h0, window_sel_q, 22'h3fffff}; // see R12

  // link state word
  wire word_t link_word = {1'b0, ~link_up_q, present_rate, 1'b0, lane_count, payload_limit,
                           3'h0, read_request_limit, 13'h0}; // see R9 see R10 see R11

  // timeout status word
  wire word_t to_word = {4'h0, dm_err_q, 3'h0, to_flags_q, 18'h0}; // see R19

  // read mux: each word is gated by its own select, then all are merged;
  // at most one select is high, so the merge never mixes two words
  wire word_t sel_flags  = {32{hit_flags}}  & irq_flags;             // see R1
  wire word_t sel_irq_en = {32{hit_irq_en}} & irq_en_q;              // see R2
  wire word_t sel_run_en = {32{hit_run_en}} & run_en_q;              // see R4
  wire word_t sel_caps   = {32{hit_caps}}   & caps_word;             // see R5
  wire word_t sel_drops  = {32{hit_drops}}  & {16'h0, link_drops_q}; // see R6
  wire word_t sel_inflt  = {32{hit_inflt}}  & inflight_q;            // see R8
  wire word_t sel_link   = {32{hit_link}}   & link_word;             // see R9
  wire word_t sel_window = {32{hit_window}} & window_word;           // see R12
  wire word_t sel_pgl    = {32{hit_pgl}}    & page_low_q;            // see R14
  wire word_t sel_pgh    = {32{hit_pgh}}    & page_high_q;           // see R15
  wire word_t sel_to     = {32{hit_to}}     & to_word;               // see R19
  // an unmapped offset selects nothing, so it reads as zero
  wire word_t rd_mux     = sel_flags | sel_irq_en | sel_run_en | sel_caps | sel_drops | sel_inflt |
                           sel_link | sel_window | sel_pgl | sel_pgh | sel_to;

  // next read data: a fresh word on a read strobe, the last one otherwise
  wire word_t rdata_d = reg_rd ? rd_mux : reg_rdata; // kept so a late sampler still sees it

  // read data register; it holds until the next read strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h0;   // cleared by reset
    end else begin
      reg_rdata <= rdata_d; // word taken at the read edge
    end
  end

  // read answer strobe, high for the one cycle after the read edge;
  // back-to-back reads give back-to-back strobes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rvalid <= 1'b0;   // no answer pending after reset
    end else begin
      reg_rvalid <= reg_rd; // answer follows every read
    end
  end

  // write strobes, one per writable word; writes to read-only or
  // unmapped offsets raise none of them and are dropped
  wire logic wr_irq_en = reg_wr & hit_irq_en; // see R2
  wire logic wr_run_en = reg_wr & hit_run_en; // see R4
  wire logic wr_inflt  = reg_wr & hit_inflt;  // see R7 see R8
  wire logic wr_window = reg_wr & hit_window; // see R12
  wire logic wr_pgl    = reg_wr & hit_pgl;    // see R14
  wire logic wr_pgh    = reg_wr & hit_pgh;    // see R15

  // interrupt enables: every bit is stored, only the low six take effect;
  // the reserved bits read back what software wrote
  ctl_word_reg #(
    .WIDTH    (32),
    .RESET_AT (32'h0)
  ) irq_en_reg (
    .clk      (clk),
    .rstn     (rstn),
    .load     (wr_irq_en),
    .load_val (reg_wdata),
    .value_q  (irq_en_q)
  );

  // path and engine enables: every bit is stored, only the low five
  // drive outputs
  ctl_word_reg #(
    .WIDTH    (32),
    .RESET_AT (32'h0)
  ) run_en_reg (
    .clk      (clk),
    .rstn     (rstn),
    .load     (wr_run_en),
    .load_val (reg_wdata),
    .value_q  (run_en_q)
  );

  // read in-flight control: the spare fields are kept only for read-back,
  // the per-engine limit is the one field that acts
  ctl_word_reg #(
    .WIDTH    (32),
    .RESET_AT (`RST_READ_INFLIGHT) // see R8
  ) inflight_reg (
    .clk      (clk),
    .rstn     (rstn),
    .load     (wr_inflt),
    .load_val (reg_wdata),
    .value_q  (inflight_q)
  );

  // window select bits: the fixed ones and zeros around them are not
  // stored, so no write can disturb them
  ctl_word_reg #(
    .WIDTH    (7),
    .RESET_AT (`RST_WINDOW_SIZE >> 22)
  ) window_reg (
    .clk      (clk),
    .rstn     (rstn),
    .load     (wr_window),
    .load_val (reg_wdata[28:22]),
    .value_q  (window_sel_q)
  );

  // page low: all bits read back, only bits 31:22 reach the target
  // address
  ctl_word_reg #(
    .WIDTH    (32),
    .RESET_AT (`RST_PAGE)
  ) page_low_reg (
    .clk      (clk),
    .rstn     (rstn),
    .load     (wr_pgl),
    .load_val (reg_wdata),
    .value_q  (page_low_q)
  );

  // page high: all 32 bits reach the target address
  // as its top word
  ctl_word_reg #(
    .WIDTH    (32),
    .RESET_AT (`RST_PAGE)
  ) page_high_reg (
    .clk      (clk),
    .rstn     (rstn),
    .load     (wr_pgh),
    .load_val (reg_wdata),
    .value_q  (page_high_q)
  );

  // training state seen at the previous edge, for the drop detector
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_l0_q <= 1'b0;  // reset counts as out of L0, so no false drop
    end else begin
      in_l0_q <= in_l0; // follows the core every cycle
    end
  end

  // link up only while the core reports it and training sits in L0;
  // either one alone is not trusted
  wire logic link_up_d = ~link_down & in_l0; // see R11

  // registered link state; its bit in the status word lags the core by one cycle, the other core fields do not
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link_up_q <= 1'b0;      // link reads down until trained
    end else begin
      link_up_q <= link_up_d; // see R11
    end
  end

  // drop counter next value: one per fall out of L0; it sticks at the top
  // rather than wrapping, so a flapping link never reads as a quiet one
  wire logic        drops_full   = &link_drops_q;            // counter at its ceiling
  wire logic        count_drop   = left_l0 & ~drops_full;    // a drop that still fits
  wire logic [15:0] link_drops_d = count_drop ? 16'(link_drops_q + 16'h1) : link_drops_q; // see R6

  // link drop counter; only a reset clears it, software cannot
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link_drops_q <= 16'h0;        // see R6
    end else begin
      link_drops_q <= link_drops_d; // count or hold
    end
  end

  // next timeout flags: a clear write empties them, but an event in the
  // same cycle still lands, so no timeout is ever lost to a racing clear
  wire logic [5:0] to_flags_d = (clear_to ? 6'h0 : to_flags_q) | to_events;      // see R16
  wire logic       dm_err_d   = (clear_to ? 1'b0 : dm_err_q) | master_cmd_error; // see R16

  // sticky read timeout flags for the slave, master and four channels
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      to_flags_q <= 6'h0;       // no timeout after reset
    end else begin
      to_flags_q <= to_flags_d; // set, hold or clear
    end
  end

  // sticky illegal master command flag
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dm_err_q <= 1'b0;     // no error after reset
    end else begin
      dm_err_q <= dm_err_d; // set, hold or clear
    end
  end

  // pending interrupt: a status bit with its enable; reserved enable
  // bits are masked so stray writes there cannot raise the line
  wire logic irq_pending = |(irq_flags & irq_en_q & `IRQ_MASK_BITS); // see R3

  // interrupt output register, one cycle behind the status and enables;
  // registered so the line toward the host never glitches
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      host_irq <= 1'b0;        // quiet after reset
    end else begin
      host_irq <= irq_pending; // see R3
    end
  end

  // master path: off while any timeout is pending, whatever the enable
  // says; it comes back by itself once the flags are cleared
  assign fpga_to_host_path_enable = run_en_q[0] & ~any_timeout; // see R18

  // engine enables and the per-engine read limit
  assign engine_enable            = run_en_q[4:1];              // see R4
  assign per_engine_read_limit    = inflight_q[27:24];          // see R7

  // target access: closed until software clears every timeout flag,
  // whatever happens to the target logic meanwhile
  assign target_access_ok         = ~any_timeout;               // see R17

  // direct-slave window and upper address bits
  assign slave_window_mask        = window_word;                // see R13
  assign slave_upper_addr         = {page_high_q, page_low_q[31:22]}; // see R14 see R15

  // fixed transfer figures of the bridge
  assign write_payload_bytes      = 8'(`WRITE_PAYLOAD_BYTES);   // see R20
  assign data_path_bits           = 10'(`DATA_PATH_BITS);       // see R21

endmodule

// one stored control word: loads on its write strobe, holds otherwise
// assumes strobe and data come from the register port on the same clock
module ctl_word_reg
  import bridge_regs_pkg::*;
#(
  parameter int          WIDTH    = 32,   // stored bits
  parameter logic [31:0] RESET_AT = 32'h0 // value after reset, low bits used
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // load side
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  // stored value
  output logic      [WIDTH-1:0] value_q
);

  // load on the strobe; the reset value is a constant of each instance
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      value_q <= RESET_AT[WIDTH-1:0]; // reset value of this word
    end else if (load) begin
      value_q <= load_val;            // host write lands here
    end
  end
endmodule

//--- bridge_regs_checker.sv
// assertions on the bridge register bank ports
// assumes it is bound to bridge_regs and shares its clock and reset
`timescale 1ns/1ps
module bridge_regs_checker (
  // clock and reset
  input wire logic         clk,
  input wire logic         rstn,
  // register port
  input wire logic         reg_wr,
  input wire logic [7:0]   reg_addr,
  input wire logic [31:0]  reg_wdata,
  // timeout events
  input wire logic         slave_read_timeout,
  input wire logic         master_read_timeout,
  input wire logic [3:0]   channel_read_timeout,
  input wire logic         master_cmd_error,
  // watched outputs
  input wire logic         target_access_ok,
  input wire logic         fpga_to_host_path_enable,
  input wire logic [3:0]   per_engine_read_limit,
  input wire logic [31:0]  slave_window_mask,
  input wire logic [63:22] slave_upper_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // any timeout event this cycle
  wire ev  = slave_read_timeout | master_read_timeout | master_cmd_error | (|channel_read_timeout);
  wire clr = reg_wr && reg_addr == 8'h34;
  // status clear write with no fresh event
  sequence clr_s;
    clr && !ev;
  endsequence
  to_set_a: assert property (ev |=> !target_access_ok)
    else $error("timeout event left target open");
  to_hold_a: assert property (!target_access_ok && !clr |=> !target_access_ok)
    else $error("target reopened without clear");
  to_clear_a: assert property (clr_s |=> target_access_ok)
    else $error("clear write did not reopen target");
  path_off_a: assert property (!target_access_ok |-> !fpga_to_host_path_enable)
    else $error("master path on during timeout");
  limit_wr_a: assert property (reg_wr && reg_addr == 8'h14 |=> per_engine_read_limit == $past(reg_wdata[27:24]))
    else $error("read limit not taken");
  mask_fix_a: assert property (slave_window_mask[21:0] == 22'h3fffff && slave_window_mask[31:29] == 3'h0)
    else $error("window mask fixed bits wrong");
  page_hi_a: assert property (reg_wr && reg_addr == 8'h24 |=> slave_upper_addr[63:32] == $past(reg_wdata))
    else $error("upper page high not taken");
  page_lo_a: assert property (reg_wr && reg_addr == 8'h20 |=> slave_upper_addr[31:22] == $past(reg_wdata[31:22]))
    else $error("upper page low not taken");
endmodule
bind bridge_regs bridge_regs_checker chk (.clk, .rstn, .reg_wr, .target_access_ok, .fpga_to_host_path_enable,
  .slave_read_timeout, .master_read_timeout, .master_cmd_error, .channel_read_timeout,
  .per_engine_read_limit, .reg_addr, .reg_wdata, .slave_window_mask, .slave_upper_addr);

//--- link_partner.sv
// model of the endpoint core feeding the status port
// assumes the bench moves link_up to train and drop the link
`timescale 1ns/1ps
module link_partner (
  input  wire logic        link_up,    // link trained when high
  output logic      [21:0] core_status // status word toward the bank
);
  // training state, read size 3, payload 1, rate 2, width 8, link down flag
  assign core_status = {link_up ? 6'h10 : 6'h02, 3'h3, 3'h1, 3'h2, 4'h8, 2'h0, ~link_up};
endmodule

//--- bridge_regs_tb_top.sv
// self-checking bench for the bridge register bank
// assumes the register port answers reads one cycle after the strobe
`timescale 1ns/1ps
module bridge_regs_tb_top;
  import bridge_regs_pkg::*;
  logic clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, link_up = 0, model_specific_flag = 0;
  logic descriptor_overlap_flag = 1, slave_read_timeout = 0, master_read_timeout = 0, master_cmd_error = 0;
  logic [3:0]   engine_irq = 4'h0, message_interrupt_compat = 4'h9, channel_read_timeout = 4'h0;
  logic [7:0]   reg_addr = 8'h00, write_payload_bytes;
  word_t        reg_wdata = 32'h0, reg_rdata, slave_window_mask;
  logic [21:0]  core_status;
  logic [3:0]   engine_enable, per_engine_read_limit;
  logic [9:0]   data_path_bits;
  logic [63:22] slave_upper_addr;
  logic         reg_rvalid, host_irq, fpga_to_host_path_enable, target_access_ok;
  int           mismatches = 0, total_checks = 0, cyc = 0;
  bridge_regs dut (
    .clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .core_status(core_status),
    .model_specific_flag(model_specific_flag), .engine_irq(engine_irq),
    .message_interrupt_compat(message_interrupt_compat), .descriptor_overlap_flag(descriptor_overlap_flag),
    .slave_read_timeout(slave_read_timeout), .master_read_timeout(master_read_timeout),
    .channel_read_timeout(channel_read_timeout), .master_cmd_error(master_cmd_error), .host_irq(host_irq),
    .fpga_to_host_path_enable(fpga_to_host_path_enable), .engine_enable(engine_enable),
    .per_engine_read_limit(per_engine_read_limit), .target_access_ok(target_access_ok),
    .slave_window_mask(slave_window_mask), .slave_upper_addr(slave_upper_addr),
    .write_payload_bytes(write_payload_bytes), .data_path_bits(data_path_bits));
  link_partner lp (.link_up(link_up), .core_status(core_status));
  // 40 MHz clock
  initial forever #12.5 clk = ~clk;
  task automatic chk(string n, logic [63:0] exp, logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, word_t d);
    @(negedge clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk) reg_wr = 0;
  endtask
  task automatic rd(logic [7:0] a, word_t e);
    @(negedge clk) {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clk) reg_rd = 0;
    chk("rvalid", 1, reg_rvalid);
    chk($sformatf("reg %h", a), e, reg_rdata);
  endtask
  task automatic report_and_stop;
    if (mismatches == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      report_and_stop;
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    rstn = 1;
    rd(8'h14, 32'ha5100100);
    rd(8'h1c, 32'h003fffff);
    rd(8'h24, 32'h0);
    wr(8'h14, 32'h37654321);
    rd(8'h14, 32'h37654321);
    chk("limit", 4'h7, per_engine_read_limit);
    wr(8'h1c, 32'hffffffff);
    rd(8'h1c, 32'h1fffffff);
    chk("window", 32'h1fffffff, slave_window_mask);
    wr(8'h20, 32'hffffffff);
    wr(8'h24, 32'h12345678);
    rd(8'h20, 32'hffffffff);
    chk("upper", {32'h12345678, 10'h3ff}, slave_upper_addr);
    wr(8'h08, 32'h1f);
    chk("run", 5'h1f, {engine_enable, fpga_to_host_path_enable});
    chk("consts", {8'h80, 10'h100}, {write_payload_bytes, data_path_bits});
    wr(8'h00, 32'hffffffff);
    rd(8'h00, 32'h0);
    rd(8'h30, 32'h0);
    {model_specific_flag, engine_irq} = 5'h15;
    wr(8'h04, 32'h2);
    repeat (3) @(negedge clk);
    rd(8'h00, 32'h16);
    chk("irq on", 1, host_irq);
    model_specific_flag = 0;
    repeat (3) @(negedge clk);
    chk("irq off", 0, host_irq);
    wr(8'h04, 32'h3c);
    repeat (3) @(negedge clk);
    chk("irq dma", 1, host_irq);
    rd(8'h0c, 32'h19);
    // each timeout source in turn, then cleared
    for (int i = 0; i < 7; i++) begin
      {master_cmd_error, channel_read_timeout, master_read_timeout, slave_read_timeout} = 7'h1 << i;
      @(negedge clk) {master_cmd_error, channel_read_timeout, master_read_timeout, slave_read_timeout} = 7'h0;
      chk("blocked", 0, target_access_ok);
      chk("path", 0, fpga_to_host_path_enable);
      rd(8'h00, 32'h15);
      rd(8'h34, 32'h1 << (i < 6 ? 18 + i : 27));
      wr(8'h34, 32'h0);
      chk("cleared", 1, target_access_ok);
    end
    link_up = 1;
    repeat (3) @(negedge clk);
    rd(8'h18, 32'h12086000);
    link_up = 0;
    repeat (3) @(negedge clk);
    rd(8'h18, 32'h52086000);
    rd(8'h10, 32'h1);
    // reset in mid-run: drop count and control word go back to reset values
    @(negedge clk) rstn = 0;
    @(negedge clk) rstn = 1;
    rd(8'h10, 32'h0);
    rd(8'h14, 32'ha5100100);
    chk("limit rst", 4'h5, per_engine_read_limit);
    report_and_stop;
  end
endmodule
